// [hufc_dev.sv]
// Character engine shared by both ends, and the device end of the serial link.
`timescale 1ns/1ns
module hufc_serdes
   import hufc_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   input  wire logic [DIV_W-1:0]  i_div,
   input  wire hufc_parity_e      i_parity,
   input  wire hufc_stop_e        i_stop,
   input  wire hufc_width_t       i_width,
   input  wire logic              i_cts_ok,
   input  wire logic              i_tx_valid,
   input  wire logic [DATA_W-1:0] i_tx_data,
   output logic                   o_tx_ready,
   output logic                   o_tx_done,
   output logic                   o_txd,
   input  wire logic              i_rxd,
   output logic                   o_rx_valid,
   output logic [DATA_W-1:0]      o_rx_data,
   output logic                   o_rx_perr,
   output logic                   o_rx_ferr,
   output logic                   o_rx_break
);
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} hufc_state_e;

   // Length of the stop interval in core clocks.
   function automatic logic [DIV_W:0] stop_len(input logic [DIV_W-1:0] d, input hufc_stop_e s);
      logic [DIV_W:0] w;
      w = {1'b0, d};
      unique case (s)
         STOP_1P5: stop_len = w + (w >> 1);
         STOP_2:   stop_len = w << 1;
         default:  stop_len = w;
      endcase
   endfunction : stop_len

   hufc_state_e       tx_st;
   hufc_state_e       rx_st;
   logic [DIV_W:0]    tx_cnt;
   logic [DIV_W:0]    rx_cnt;
   logic [DATA_W-1:0] tx_sh;
   logic [DATA_W-1:0] rx_sh;
   logic [2:0]        tx_bit;
   logic [2:0]        rx_bit;
   logic              tx_par;
   logic              rx_par;
   logic [2:0]        last_bit;
   logic [DIV_W:0]    bit_len;

   assign last_bit = 3'(CHAR_MIN - 1) + {1'b0, i_width};
   assign bit_len  = {1'b0, i_div} - 1'b1;

   // A new character starts only in idle and only while the far end grants it.
   // gate on clear
   assign o_tx_ready = i_ce && (tx_st == S_IDLE) && i_cts_ok;

   // Transmit serialiser; a character once started always runs to its stop bits.
   // serialise words
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_st     <= S_IDLE;
         tx_cnt    <= '0;
         tx_sh     <= '0;
         tx_bit    <= '0;
         tx_par    <= 1'b0;
         o_txd     <= 1'b1;
         o_tx_done <= 1'b0;
      end else if (i_ce) begin
         o_tx_done <= 1'b0;
         if (tx_st == S_IDLE) begin
            o_txd <= 1'b1;
            if (i_tx_valid && o_tx_ready) begin
               tx_sh  <= i_tx_data;
               tx_par <= (i_parity == PAR_ODD);
               tx_cnt <= bit_len;
               o_txd  <= 1'b0;
               tx_st  <= S_START;
            end
         end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
         end else begin
            tx_cnt <= bit_len;
            unique case (tx_st)
               S_START: begin
                  o_txd  <= tx_sh[0];
                  tx_par <= tx_par ^ tx_sh[0];
                  tx_sh  <= tx_sh >> 1;
                  tx_bit <= '0;
                  tx_st  <= S_DATA;
               end
               S_DATA: begin
                  if (tx_bit == last_bit) begin
                     if (i_parity == PAR_NONE) begin
                        o_txd  <= 1'b1;
                        tx_cnt <= stop_len(i_div, i_stop) - 1'b1;
                        tx_st  <= S_STOP;
                     end else begin
                        o_txd <= tx_par;
                        tx_st <= S_PAR;
                     end
                  end else begin
                     o_txd  <= tx_sh[0];
                     tx_par <= tx_par ^ tx_sh[0];
                     tx_sh  <= tx_sh >> 1;
                     tx_bit <= tx_bit + 1'b1;
                  end
               end
               S_PAR: begin
                  o_txd  <= 1'b1;
                  tx_cnt <= stop_len(i_div, i_stop) - 1'b1;
                  tx_st  <= S_STOP;
               end
               S_STOP: begin
                  o_tx_done <= 1'b1;
                  tx_st     <= S_IDLE;
               end
               S_IDLE: tx_st <= S_IDLE;
            endcase
         end
      end
   end

   // Receive deserialiser; bits are sampled in the middle of each period.
   // deserialise characters
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_st      <= S_IDLE;
         rx_cnt     <= '0;
         rx_sh      <= '0;
         rx_bit     <= '0;
         rx_par     <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data  <= '0;
         o_rx_perr  <= 1'b0;
         o_rx_ferr  <= 1'b0;
         o_rx_break <= 1'b0;
      end else if (i_ce) begin
         o_rx_valid <= 1'b0;
         if (rx_st == S_IDLE) begin
            if (!i_rxd) begin
               rx_cnt <= {2'b00, i_div[DIV_W-1:1]};
               rx_st  <= S_START;
            end
         end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
         end else begin
            rx_cnt <= bit_len;
            unique case (rx_st)
               S_START: begin
                  // A start bit that has gone high by mid-period was a glitch.
                  rx_st     <= i_rxd ? S_IDLE : S_DATA;
                  rx_bit    <= '0;
                  rx_par    <= (i_parity == PAR_ODD);
                  o_rx_perr <= 1'b0;
               end
               S_DATA: begin
                  rx_sh  <= {i_rxd, rx_sh[DATA_W-1:1]};
                  rx_par <= rx_par ^ i_rxd;
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == last_bit) begin
                     rx_st <= (i_parity == PAR_NONE) ? S_STOP : S_PAR;
                  end
               end
               S_PAR: begin
                  o_rx_perr <= (i_rxd != rx_par);
                  rx_st     <= S_STOP;
               end
               S_STOP: begin
                  // Only the first stop bit is checked so back-to-back characters are kept.
                  o_rx_valid <= 1'b1;
                  o_rx_data  <= rx_sh >> (2'd3 - i_width);
                  o_rx_ferr  <= !i_rxd;
                  o_rx_break <= !i_rxd && (rx_sh == '0) && !rx_par;
                  rx_st      <= S_IDLE;
               end
               S_IDLE: rx_st <= S_IDLE;
            endcase
         end
      end
   end
endmodule : hufc_serdes

module hufc_dev
   import hufc_pkg::*;
#(
   parameter int DEPTH = RX_DEPTH
)
(
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_SYS_RST,
   input  wire logic              I_CE,
   input  wire logic [DIV_W-1:0]  I_BAUD_DIV,
   input  wire hufc_parity_e      I_PARITY,
   input  wire hufc_stop_e        I_STOP,
   input  wire hufc_width_t       I_WIDTH,
   input  wire logic              I_FLOW_EN,
   input  wire logic              I_LINK_UP,
   input  wire logic              I_TX_VALID,
   input  wire logic [DATA_W-1:0] I_TX_DATA,
   output logic                   O_TX_READY,
   output logic                   O_RX_VALID,
   output logic [DATA_W-1:0]      O_RX_DATA,
   input  wire logic              I_RX_READY,
   output logic [EV_COUNT-1:0]    O_EVENTS,
   output logic                   O_CMD_MODE,
   hufc_link_if.dev               LINK
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   logic [DATA_W-1:0] mem [DEPTH];
   logic [PW-1:0]     wr_ptr;
   logic [PW-1:0]     rd_ptr;
   logic [PW:0]       count;
   logic              cts_ok;
   logic              rx_valid;
   logic [DATA_W-1:0] rx_data;
   logic              rx_perr;
   logic              rx_ferr;
   logic              rx_break;
   logic              tx_done;
   logic              push;
   logic              pop;
   logic              full;
   logic              prev_cts_n;
   logic              prev_rts_n;
   logic              prev_ready;

   // With flow control off the far end is always allowed to receive.
   // flow select
   assign cts_ok = !I_FLOW_EN || !LINK.host_rts_n;

   // The single channel: device transmits on its own line and listens on the host's.
   // one channel
   hufc_serdes u_serdes (
      .i_clk      (I_CORE_CLK),
      .i_rst      (I_SYS_RST),
      .i_ce       (I_CE),
      .i_div      (I_BAUD_DIV),
      .i_parity   (I_PARITY),
      .i_stop     (I_STOP),
      .i_width    (I_WIDTH),
      .i_cts_ok   (cts_ok),
      .i_tx_valid (I_TX_VALID),
      .i_tx_data  (I_TX_DATA),
      .o_tx_ready (O_TX_READY),
      .o_tx_done  (tx_done),
      .o_txd      (LINK.dev_txd),
      .i_rxd      (LINK.host_txd),
      .o_rx_valid (rx_valid),
      .o_rx_data  (rx_data),
      .o_rx_perr  (rx_perr),
      .o_rx_ferr  (rx_ferr),
      .o_rx_break (rx_break)
   );

   assign full       = (count == (PW + 1)'(DEPTH));
   assign push       = I_CE && rx_valid && !full;
   assign pop        = I_CE && O_RX_VALID && I_RX_READY;
   assign O_RX_VALID = (count != '0);
   assign O_RX_DATA  = mem[rd_ptr];

   // Request is withdrawn while one word waits, leaving a free entry for a word in flight.
   // early deassert
   assign LINK.dev_rts_n = I_FLOW_EN && (count >= (PW + 1)'(DEPTH - 1));

   // Mode pin only has meaning while the wireless link is up.
   // mode select
   assign O_CMD_MODE = I_LINK_UP && LINK.mode_select_pin;

   // Receive buffer storage.
   always_ff @(posedge I_CORE_CLK) begin
      if (push) begin
         mem[wr_ptr] <= rx_data;
      end
   end

   // Receive buffer pointers and fill level.
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= ptr_inc(rd_ptr);
         end
         count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   // Event pulses, one core cycle each.
   // ten causes
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_EVENTS   <= '0;
         prev_cts_n <= 1'b0; // Idle levels, so no false change follows reset.
         prev_rts_n <= 1'b0;
         prev_ready <= 1'b1;
      end else if (I_CE) begin
         prev_cts_n              <= LINK.host_rts_n;
         prev_rts_n              <= LINK.dev_rts_n;
         prev_ready              <= O_TX_READY;
         O_EVENTS[EV_RX_DONE]    <= rx_valid;
         O_EVENTS[EV_TX_DONE]    <= tx_done;
         O_EVENTS[EV_PAR_ERR]    <= rx_valid && rx_perr;
         O_EVENTS[EV_FRM_ERR]    <= rx_valid && rx_ferr;
         O_EVENTS[EV_OVERRUN]    <= rx_valid && full;
         O_EVENTS[EV_BREAK]      <= rx_valid && rx_break;
         O_EVENTS[EV_CTS_CHG]    <= prev_cts_n != LINK.host_rts_n;
         O_EVENTS[EV_RTS_CHG]    <= prev_rts_n != LINK.dev_rts_n;
         O_EVENTS[EV_BUF_FULL]   <= push && !pop && (count == (PW + 1)'(DEPTH - 1));
         O_EVENTS[EV_TX_EMPTY]   <= O_TX_READY && !prev_ready;
      end else begin
         O_EVENTS <= '0;
      end
   end
endmodule : hufc_dev

// [hufc_host.sv]
// Host end of the serial link: one word holding register and its own handshake.
`timescale 1ns/1ns
module hufc_host
   import hufc_pkg::*;
(
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_SYS_RST,
   input  wire logic              I_CE,
   input  wire logic [DIV_W-1:0]  I_BAUD_DIV,
   input  wire hufc_parity_e      I_PARITY,
   input  wire hufc_stop_e        I_STOP,
   input  wire hufc_width_t       I_WIDTH,
   input  wire logic              I_FLOW_EN,
   input  wire logic              I_CMD_MODE,
   input  wire logic              I_TX_VALID,
   input  wire logic [DATA_W-1:0] I_TX_DATA,
   output logic                   O_TX_READY,
   output logic                   O_RX_VALID,
   output logic [DATA_W-1:0]      O_RX_DATA,
   output logic                   O_RX_PERR,
   output logic                   O_RX_FERR,
   input  wire logic              I_RX_READY,
   hufc_link_if.host              LINK
);
   logic              cts_ok;
   logic              rx_valid;
   logic [DATA_W-1:0] rx_data;
   logic              rx_perr;
   logic              rx_ferr;

   // Host sends nothing while the device withdraws its request; the two handshake
   // wires stay separate so flow control is never defeated by a loop.
   // honour request
   assign cts_ok = !I_FLOW_EN || !LINK.dev_rts_n;

   hufc_serdes u_serdes (
      .i_clk      (I_CORE_CLK),
      .i_rst      (I_SYS_RST),
      .i_ce       (I_CE),
      .i_div      (I_BAUD_DIV),
      .i_parity   (I_PARITY),
      .i_stop     (I_STOP),
      .i_width    (I_WIDTH),
      .i_cts_ok   (cts_ok),
      .i_tx_valid (I_TX_VALID),
      .i_tx_data  (I_TX_DATA),
      .o_tx_ready (O_TX_READY),
      .o_tx_done  (),
      .o_txd      (LINK.host_txd),
      .i_rxd      (LINK.dev_txd),
      .o_rx_valid (rx_valid),
      .o_rx_data  (rx_data),
      .o_rx_perr  (rx_perr),
      .o_rx_ferr  (rx_ferr),
      .o_rx_break ()
   );

   // Request is withdrawn, low being the grant, while a received word waits.
   // active low
   assign LINK.host_rts_n = I_FLOW_EN && O_RX_VALID;

   // Holding register; a word arriving while one waits overwrites it.
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_RX_VALID <= 1'b0;
         O_RX_DATA  <= '0;
         O_RX_PERR  <= 1'b0;
         O_RX_FERR  <= 1'b0;
      end else if (I_CE) begin
         if (rx_valid) begin
            O_RX_VALID <= 1'b1;
            O_RX_DATA  <= rx_data;
            O_RX_PERR  <= rx_perr;
            O_RX_FERR  <= rx_ferr;
         end else if (I_RX_READY) begin
            O_RX_VALID <= 1'b0;
         end
      end
   end

   // Mode level driven toward the device.
   // mode select
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         LINK.mode_select_pin <= 1'b0;
      end else if (I_CE) begin
         LINK.mode_select_pin <= I_CMD_MODE;
      end
   end
endmodule : hufc_host

// [hufc_link_if.sv]
// Serial link wires joining the device end and the host end.
`timescale 1ns/1ns
interface hufc_link_if;
   logic dev_txd;
   logic host_txd;
   logic dev_rts_n;
   logic host_rts_n;
   logic mode_select_pin;

   modport dev  (output dev_txd, output dev_rts_n, input host_txd, input host_rts_n, input mode_select_pin);
   modport host (output host_txd, output host_rts_n, output mode_select_pin, input dev_txd, input dev_rts_n);
endinterface : hufc_link_if

// [hufc_link_sva.sv]
// Checker for the serial link wires between the device end and the host end.
`timescale 1ns/1ns
module hufc_link_sva (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic dev_txd,
   input wire logic host_txd,
   input wire logic dev_rts_n,
   input wire logic host_rts_n,
   input wire logic mode_select_pin
);
   // Bit runs assume eight clocks a bit or more; a whole frame never exceeds twelve bits.
   localparam int FRAME = 96;
   logic [7:0] dev_wait;
   logic [7:0] host_wait;

   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   // Cycles each receiver has withheld its grant; saturates so a long hold never wraps to zero.
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         dev_wait  <= 8'h00;
         host_wait <= 8'h00;
      end else begin
         dev_wait  <= dev_rts_n ? dev_wait + 8'(dev_wait != 8'hFF) : 8'h00;
         host_wait <= host_rts_n ? host_wait + 8'(host_wait != 8'hFF) : 8'h00;
      end
   end

   // Line levels, idle state and the grant handshake.
   a_dev_low_run: assert property ($fell(dev_txd) |-> !dev_txd [*8]) else $error("short dev low");
   a_host_low_run: assert property ($fell(host_txd) |-> !host_txd [*8]) else $error("short host low");
   a_dev_high_run: assert property ($rose(dev_txd) |-> dev_txd [*8]) else $error("short dev high");
   a_host_high_run: assert property ($rose(host_txd) |-> host_txd [*8]) else $error("short host high");
   a_reset_idle: assert property ($fell(I_SYS_RST) |-> dev_txd && host_txd && !mode_select_pin)
      else $error("lines not idle after reset");
   a_rts_granted: assert property ($fell(I_SYS_RST) |-> !dev_rts_n && !host_rts_n)
      else $error("grant missing after reset");
   a_dev_gated: assert property (host_wait > FRAME |-> dev_txd) else $error("device sent while denied");
   a_host_gated: assert property (dev_wait > FRAME |-> host_txd) else $error("host sent while denied");
endmodule : hufc_link_sva

// [hufc_pkg.sv]
// Shared constants, types and event layout for the host serial port with flow control.
// Notes on behaviour
// - One full-duplex asynchronous serial channel.
// - Receive deserialised, transmit serialised, parallel words.
// - Ten distinct event causes raised.
// - Data lines cross between both ends.
// - Request and clear to send active low.
// - Host stops sending while request deasserted.
// - Do not loop request back onto clear.
// - Baud 1200 to 230400, default 115200.
// - Flow control is handshake or none.
// - Parity none, odd or even, checked.
// - Stop bits one, one and half, two.
// - Character width five to eight bits.
// - Mode pin high command, low transparent.
package hufc_pkg;
   localparam int CLK_HZ       = 50_000_000;
   localparam int BAUD_MIN     = 1200;
   localparam int BAUD_DEFAULT = 115200;
   localparam int BAUD_MAX     = 230400;
   localparam int DIV_W        = 16;
   localparam int DATA_W       = 8;
   localparam int CHAR_MIN     = 5;
   localparam int RX_DEPTH     = 2;
   localparam int EV_COUNT     = 10;

   // Bit periods in core clocks; rounding down keeps the error under one percent at the top rate.
   localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [DIV_W-1:0] DIV_MIN     = DIV_W'(CLK_HZ / BAUD_MAX);
   localparam logic [DIV_W-1:0] DIV_MAX     = DIV_W'(CLK_HZ / BAUD_MIN);

   // Positions of the event causes in the event vector.
   localparam int EV_RX_DONE   = 0;
   localparam int EV_TX_DONE   = 1;
   localparam int EV_PAR_ERR   = 2;
   localparam int EV_FRM_ERR   = 3;
   localparam int EV_OVERRUN   = 4;
   localparam int EV_BREAK     = 5;
   localparam int EV_CTS_CHG   = 6;
   localparam int EV_RTS_CHG   = 7;
   localparam int EV_BUF_FULL  = 8;
   localparam int EV_TX_EMPTY  = 9;

   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} hufc_parity_e;
   typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} hufc_stop_e;
   typedef logic [1:0] hufc_width_t;
endpackage : hufc_pkg

// [tb_top.sv]
// Self-checking bench joining the device end and the host end across the serial link.
`timescale 1ns/1ns
module tb_top
   import hufc_pkg::*;
;
   logic                clk;
   logic                rst;
   logic [DIV_W-1:0]    div;
   hufc_parity_e        par;
   hufc_parity_e        hpar;
   hufc_stop_e          stop;
   hufc_width_t         wid;
   logic                flow;
   logic                link_up;
   logic                cmd;
   logic                d_cmd;
   logic                h_pe;
   logic                h_fe;
   logic                ce;
   logic [EV_COUNT-1:0] ev;
   logic                tv [2];
   logic [7:0]          td [2];
   logic                tr [2];
   logic                rv [2];
   logic [7:0]          rd [2];
   logic                rr [2];
   int                  ev_cnt [EV_COUNT];
   int                  errors;
   int                  tests_run;
   int                  cycles;

   hufc_link_if hufc_link_if_inst ();

   // Index 0 of the stream arrays is the device end, index 1 the host end.
   hufc_dev hufc_dev_inst (.I_CORE_CLK (clk), .I_SYS_RST (rst), .I_CE (ce), .I_BAUD_DIV (div),
      .I_PARITY (par), .I_STOP (stop), .I_WIDTH (wid), .I_FLOW_EN (flow), .I_LINK_UP (link_up),
      .I_TX_VALID (tv[0]), .I_TX_DATA (td[0]), .O_TX_READY (tr[0]), .O_RX_VALID (rv[0]),
      .O_RX_DATA (rd[0]), .I_RX_READY (rr[0]), .O_EVENTS (ev), .O_CMD_MODE (d_cmd), .LINK (hufc_link_if_inst));
   hufc_host hufc_host_inst (.I_CORE_CLK (clk), .I_SYS_RST (rst), .I_CE (ce), .I_BAUD_DIV (div),
      .I_PARITY (hpar), .I_STOP (stop), .I_WIDTH (wid), .I_FLOW_EN (flow), .I_CMD_MODE (cmd),
      .I_TX_VALID (tv[1]), .I_TX_DATA (td[1]), .O_TX_READY (tr[1]), .O_RX_VALID (rv[1]),
      .O_RX_DATA (rd[1]), .O_RX_PERR (h_pe), .O_RX_FERR (h_fe), .I_RX_READY (rr[1]), .LINK (hufc_link_if_inst));
   hufc_link_sva hufc_link_sva_inst (.I_CORE_CLK (clk), .I_SYS_RST (rst), .dev_txd (hufc_link_if_inst.dev_txd),
      .host_txd (hufc_link_if_inst.host_txd), .dev_rts_n (hufc_link_if_inst.dev_rts_n),
      .host_rts_n (hufc_link_if_inst.host_rts_n), .mode_select_pin (hufc_link_if_inst.mode_select_pin));

   // Free-running core clock.
   always #10 clk = ~clk;

   // Event pulses are tallied on the falling edge, clear of the edge that launches them; a hang hits the ceiling.
   always @(negedge clk) begin
      for (int i = 0; i < EV_COUNT; i++) ev_cnt[i] += int'(ev[i] === 1'b1);
      cycles++;
      if (cycles == 60000) begin
         errors++;
         stop_test();
      end
   end

   task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // Offers a word from end s; a refused offer is withdrawn, a taken one is followed bit by bit on its line.
   task automatic send(input bit s, input logic [7:0] d, output bit ok);
      logic [11:0] f;
      logic [7:0]  m;
      int          nb;
      hufc_parity_e pp;
      ok = 1'b0;
      @(posedge clk);
      #1;
      tv[s] = 1'b1;
      td[s] = d;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(negedge clk);
         ok = tr[s] === 1'b1;
      end
      @(posedge clk);
      #1;
      tv[s] = 1'b0;
      if (!ok) return;
      m = d & (8'hFF >> (2'd3 - wid));
      f = {3'h0, m, 1'b0};
      nb = 6 + int'(wid);
      pp = s ? hpar : par;
      if (pp != PAR_NONE) begin
         f[nb] = (pp == PAR_ODD) ? ~^m : ^m;
         nb++;
      end
      f[nb] = 1'b1;
      repeat (div / 2 - 1) @(negedge clk);
      for (int k = 0; k <= nb; k++) begin
         check("line bit", 16'(s ? hufc_link_if_inst.host_txd : hufc_link_if_inst.dev_txd), 16'(f[k]));
         if (k < nb) repeat (div) @(negedge clk);
      end
   endtask : send

   // Waits for a word at end s, judges it and pops it with a one-cycle ready.
   task automatic recv(input bit s, input logic [7:0] e);
      for (int n = 0; n < 8000 && rv[s] !== 1'b1; n++) @(negedge clk);
      check("rx data", 16'(rd[s]), 16'(e));
      if (s) check("parity flag", 16'(h_pe), 16'(hpar != par));
      if (s) check("frame flag", 16'(h_fe), 16'h0000);
      @(posedge clk);
      #1;
      rr[s] = 1'b1;
      @(posedge clk);
      #1;
      rr[s] = 1'b0;
   endtask : recv

   task automatic sc_formats();
      bit         a;
      bit         b;
      logic [7:0] d;
      logic [7:0] m;
      int         n;
      for (int w = 0; w < 4; w++) begin
         for (int p = 0; p < 3; p++) begin
            repeat (3 * div) @(posedge clk);
            #1;
            wid = 2'(w);
            par = hufc_parity_e'(p);
            hpar = par;
            stop = hufc_stop_e'(p);
            d = 8'hA6 ^ 8'(w * 16 + p);
            m = 8'hFF >> (3 - w);
            fork
               send(1'b0, d, a);
               send(1'b1, ~d, b);
            join
            check("both taken", 16'({a, b}), 16'h0003);
            // Falling edges from the stop sample until the device may take its next word.
            n = 0;
            while (tr[0] !== 1'b1 && n < 100) begin
               @(negedge clk);
               n++;
            end
            check("stop length", 16'(n), 16'(div / 2 + p * div / 2 + 2));
            recv(1'b1, d & m);
            recv(1'b0, ~d & m);
         end
      end
      repeat (3 * div) @(posedge clk);
      check("rx events", 16'(ev_cnt[EV_RX_DONE]), 16'h000C);
      check("tx events", 16'(ev_cnt[EV_TX_DONE]), 16'h000C);
   endtask : sc_formats

   task automatic sc_buffer();
      bit a;
      #1;
      stop = STOP_1;
      for (int i = 0; i < 3; i++) send(1'b1, 8'h11 * 8'(i + 1), a);
      repeat (2 * div) @(posedge clk);
      check("overrun events", 16'(ev_cnt[EV_OVERRUN]), 16'h0001);
      check("full events", 16'(ev_cnt[EV_BUF_FULL]), 16'h0001);
      check("rts without flow", 16'(hufc_link_if_inst.dev_rts_n), 16'h0000);
      recv(1'b0, 8'h11);
      recv(1'b0, 8'h22);
      check("drained", 16'(rv[0]), 16'h0000);
   endtask : sc_buffer

   // A held word withdraws the grant; the other end's next word waits until the pop.
   task automatic sc_flow();
      bit a;
      flow = 1'b1;
      for (int i = 0; i < 2; i++) begin
         send(1'(i), 8'h3C, a);
         repeat (div) @(posedge clk);
         check("rts withheld", 16'(i ? hufc_link_if_inst.dev_rts_n : hufc_link_if_inst.host_rts_n), 16'h0001);
         check("no loop", 16'(i ? hufc_link_if_inst.host_rts_n : hufc_link_if_inst.dev_rts_n), 16'h0000);
         send(1'(i), 8'hC3, a);
         check("send refused", 16'(a), 16'h0000);
         recv(1'(1 - i), 8'h3C);
         send(1'(i), 8'hC3, a);
         check("send resumed", 16'(a), 16'h0001);
         recv(1'(1 - i), 8'hC3);
      end
      repeat (2) @(posedge clk);
      #1;
      check("cts events", 16'(ev_cnt[EV_CTS_CHG]), 16'h0004);
      check("rts events", 16'(ev_cnt[EV_RTS_CHG]), 16'h0004);
      flow = 1'b0;
   endtask : sc_flow

   task automatic sc_perr();
      bit a;
      par = PAR_ODD;
      hpar = PAR_EVEN;
      send(1'b0, 8'h6B, a);
      recv(1'b1, 8'h6B);
      hpar = PAR_ODD;
      par = PAR_EVEN;
      send(1'b1, 8'h6B, a);
      recv(1'b0, 8'h6B);
      check("parity events", 16'(ev_cnt[EV_PAR_ERR]), 16'h0001);
      par = PAR_ODD;
   endtask : sc_perr

   task automatic sc_mode();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         link_up = i[0];
         cmd = i[1];
         repeat (3) @(negedge clk);
         check("command mode", 16'(d_cmd), 16'(i[0] & i[1]));
      end
      // With the enable low both ends hold their state, so the mode pin keeps its old level, but the device's event pulses clear and the ready outputs drop.
      @(posedge clk);
      #1;
      ce = 1'b0;
      cmd = 1'b0;
      repeat (3) @(negedge clk);
      check("frozen mode", 16'(d_cmd), 16'h0001);
      check("frozen ready", 16'(tr[0]), 16'h0000);
      @(posedge clk);
      #1;
      ce = 1'b1;
      repeat (3) @(negedge clk);
      check("command mode", 16'(d_cmd), 16'h0000);
   endtask : sc_mode

   task automatic sc_baud();
      bit a;
      for (int i = 0; i < 2; i++) begin
         repeat (3 * div) @(posedge clk);
         #1;
         div = i ? DIV_MIN : DIV_DEFAULT;
         send(1'b1, 8'h96, a);
         recv(1'b0, 8'h96);
      end
   endtask : sc_baud

   // Reset for three cycles, then the scenarios in turn.
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      div = 16'h0008;
      par = PAR_NONE;
      hpar = PAR_NONE;
      stop = STOP_1;
      wid = 2'd3;
      flow = 1'b0;
      link_up = 1'b0;
      cmd = 1'b0;
      ce = 1'b1;
      tv = '{1'b0, 1'b0};
      td = '{8'h00, 8'h00};
      rr = '{1'b0, 1'b0};
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      sc_formats();
      sc_buffer();
      sc_flow();
      sc_perr();
      sc_mode();
      sc_baud();
      stop_test();
   end
endmodule : tb_top
